//--- common/clk_ctrl_pkg.sv
// constants, register map and bus carriers of the clock select and divide block
// How it works
// RULE1 - accept 32MHz RC and 32kHz RC sources
// RULE2 - accept 192MHz PLL as high-speed source
// RULE3 - accept 16MHz pad and 32kHz pad clocks
// RULE4 - first gate register: 1 passes, resets 8C
// RULE5 - second gate register gates eight more modules
// RULE6 - third gate register, bits 3 and 7 reserved
// RULE7 - bits 6:5 choose system clock source
// RULE8 - system clock equals high-speed over divider
// RULE9 - software never programs divider 0 or 1
// RULE10 - two-bit high-speed source select across registers
// RULE11 - converter clock runs only when enabled
// RULE12 - converter step 11 bits, mod 12 bits
// RULE13 - converter rate is high-speed times step/mod
// RULE14 - software keeps mod at least twice step
// RULE15 - mic clock enable, 7-bit step, 8-bit mod
// RULE16 - mic pin carries 32kHz or divider output
// RULE17 - mux bit 0 picks 32kHz source
// RULE18 - mux bit 2 picks USB PHY clock
// RULE19 - mux bits 7:4 low-power divider, reset 14
// RULE20 - source and gate changes at period boundaries
package clk_ctrl_pkg;

  localparam int CLK_MHZ = 50;
  localparam int PLL_MHZ = 192;
  localparam int USB_MHZ = 48;
  localparam int USB_DIV = PLL_MHZ / USB_MHZ;

  localparam int ADDR_W = 12;
  localparam int NREG = 14;

  // register slots
  localparam int S_GATE0 = 0;
  localparam int S_GATE1 = 1;
  localparam int S_GATE2 = 2;
  localparam int S_SYSSEL = 3;
  localparam int S_AUSTEP = 4;
  localparam int S_AUMOD = 5;
  localparam int S_ADCSTEP = 6;
  localparam int S_ADCMOD = 7;
  localparam int S_ADCHI = 8;
  localparam int S_MICSTEP = 9;
  localparam int S_MICMOD = 10;
  localparam int S_FHSSEL = 11;
  localparam int S_REGMOD = 12;
  localparam int S_MUX = 13;

  typedef logic [NREG-1:0][7:0] byte_vec_t;

  // register index; byte address is four times the index
  localparam byte_vec_t REG_IDX = {8'h73, 8'h71, 8'h70, 8'h6D, 8'h6C, 8'h6B, 8'h6A,
                                   8'h69, 8'h68, 8'h67, 8'h66, 8'h65, 8'h64, 8'h63};
  localparam byte_vec_t REG_RST = {8'h14, 8'h00, 8'h00, 8'h02, 8'h01, 8'h00, 8'h02,
                                   8'h00, 8'h02, 8'h33, 8'hFF, 8'h00, 8'h00, 8'h8C};
  localparam byte_vec_t REG_MASK = {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h77, 8'hFF, 8'hFF};

  // field positions
  localparam int SYS_DIV_LSB = 0;
  localparam int SYS_DIV_W = 5;
  localparam int SYS_SRC_LSB = 5;
  localparam int FHS_LO_BIT = 7;
  localparam int FHS_HI_BIT = 0;
  localparam int ADC_EN_BIT = 7;
  localparam int ADC_STEPH_LSB = 4;
  localparam int ADC_MODH_LSB = 0;
  localparam int MIC_EN_BIT = 7;
  localparam int MUX_32K_BIT = 0;
  localparam int MUX_MIC_BIT = 1;
  localparam int MUX_USB_BIT = 2;
  localparam int MUX_LPR_LSB = 4;

  localparam int STEP_W = 11;
  localparam int MOD_W = 12;

  // system source codes
  localparam logic [1:0] SYS_RC32M = 2'h0;
  localparam logic [1:0] SYS_HSDIV = 2'h1;
  localparam logic [1:0] SYS_PAD16 = 2'h2;
  localparam logic [1:0] SYS_PAD32K = 2'h3;
  // high-speed source codes
  localparam logic [1:0] FHS_PLL = 2'h0;
  localparam logic [1:0] FHS_RC = 2'h1;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

endpackage

//--- dv/clock_select_divide_tb.sv
// self-checking testbench of the clock select and divide block
module clock_select_divide_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import clk_ctrl_pkg::*;

  typedef struct {
    logic [7:0] idx;
    logic [7:0] val;
    int out;
    int exp;
  } row_t;

  logic clock;
  logic nrst;
  apb_req_t apb_in;
  apb_rsp_t apb_out;
  logic src_pll192, src_pll48, src_rc32m, src_pad16m, src_rc32k, src_pad32k;
  logic fhs_tick_q, sys_tick_q, adc_tick_q, mic_tick_q, usb_phy_tick_q, slow_tick_q;
  logic [7:0] gate0, gate1, gate2;
  logic [3:0] lpr;
  logic [5:0] ticks;
  logic [31:0] rd;
  logic err;
  logic [7:0] w;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int cnt [6];
  logic [7:0] ridx [14] = '{8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6A, 8'h6B,
                            8'h6C, 8'h6D, 8'h70, 8'h71, 8'h73};
  logic [7:0] rrst [14] = '{8'h8C, 8'h00, 8'h00, 8'hFF, 8'h33, 8'h02, 8'h00, 8'h02, 8'h00,
                            8'h01, 8'h02, 8'h00, 8'h00, 8'h14};
  // register write, then output index (0 sys 1 fhs 2 adc 3 mic 4 usb 5 slow) and ticks in 480
  row_t rows [18] = '{
    '{8'h66, 8'h24, 0, 120},
    '{8'h66, 8'hA4, 0, 60},
    '{8'h70, 8'h01, 0, 40},
    '{8'h66, 8'h04, 0, 240},
    '{8'h66, 8'h44, 0, 160},
    '{8'h66, 8'h64, 0, 30},
    '{8'h70, 8'h00, 1, 480},
    '{8'h66, 8'h24, 0, 120},
    '{8'h69, 8'h01, 2, 0},
    '{8'h6A, 8'h04, 2, 0},
    '{8'h6B, 8'h80, 2, 120},
    '{8'h6B, 8'h00, 2, 0},
    '{8'h6D, 8'h06, 3, 0},
    '{8'h6C, 8'h81, 3, 80},
    '{8'h73, 8'h16, 3, 60},
    '{8'h73, 8'h17, 5, 30},
    '{8'h73, 8'h13, 4, 96},
    '{8'h73, 8'h17, 4, 120}};

  assign ticks = {slow_tick_q, usb_phy_tick_q, mic_tick_q, adc_tick_q, fhs_tick_q, sys_tick_q};

  clock_select_divide uut (
    .clock(clock),
    .nrst(nrst),
    .apb_in(apb_in),
    .apb_out(apb_out),
    .src_pll192(src_pll192),
    .src_pll48(src_pll48),
    .src_rc32m(src_rc32m),
    .src_pad16m(src_pad16m),
    .src_rc32k(src_rc32k),
    .src_pad32k(src_pad32k),
    .fhs_tick_q(fhs_tick_q),
    .sys_tick_q(sys_tick_q),
    .adc_tick_q(adc_tick_q),
    .mic_tick_q(mic_tick_q),
    .usb_phy_tick_q(usb_phy_tick_q),
    .slow_tick_q(slow_tick_q),
    .module_gate_first_q(gate0),
    .module_gate_second_q(gate1),
    .module_gate_third_q(gate2),
    .lowpower_div_q(lpr)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // periodic source ticks, periods in clock cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    src_pll192 <= 1'b1;
    src_pll48 <= (cyc % 5 == 0);
    src_rc32m <= (cyc % 2 == 0);
    src_pad16m <= (cyc % 3 == 0);
    src_rc32k <= (cyc % 8 == 0);
    src_pad32k <= (cyc % 16 == 0);
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    apb_in.psel <= 1'b1;
    apb_in.penable <= 1'b0;
    apb_in.pwrite <= wr;
    apb_in.paddr <= {2'h0, idx, 2'h0};
    apb_in.pwdata <= {24'h0, wd};
    @(posedge clock);
    apb_in.penable <= 1'b1;
    @(posedge clock);
    while (apb_out.pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clock);
    end
    if (n == 20) n_fail++;
    rd = apb_out.prdata;
    err = apb_out.pslverr;
    apb_in.psel <= 1'b0;
    apb_in.penable <= 1'b0;
  endtask

  // settle after a selection change, then count output ticks over 480 cycles
  task automatic count_win;
    repeat (100) @(posedge clock);
    cnt = '{default: 0};
    repeat (480) begin
      @(posedge clock);
      #1;
      for (int k = 0; k < 6; k++) cnt[k] += ticks[k];
    end
  endtask

  // bit 7 clear keeps both fractional dividers disabled whatever step and mod hold
  function automatic logic [7:0] wv(input int i);
    return (8'h5A + 8'(i * 17)) & 8'h7F;
  endfunction

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    apb_in = '0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    chk("gate first", gate0, 8'h8C);
    chk("gate second", gate1, 8'h00);
    chk("gate third", gate2, 8'h00);
    chk("lowpower div", lpr, 4'h1);
    for (int i = 0; i < 14; i++) begin
      apb(1'b0, ridx[i], 8'h00);
      chk("reset value", rd, {24'h0, rrst[i]});
    end
    for (int i = 0; i < 18; i++) begin
      apb(1'b1, rows[i].idx, rows[i].val);
      count_win();
      chk("tick count", cnt[rows[i].out], rows[i].exp);
    end
    // unmapped word: refused and reads zero
    apb(1'b1, 8'h6E, 8'hFF);
    chk("unmapped write err", err, 1'b1);
    apb(1'b0, 8'h6E, 8'h00);
    chk("unmapped read err", err, 1'b1);
    chk("unmapped read data", rd, 32'h0);
    for (int i = 0; i < 14; i++) apb(1'b1, ridx[i], wv(i));
    for (int i = 0; i < 14; i++) begin
      apb(1'b0, ridx[i], 8'h00);
      chk("readback", rd, {24'h0, wv(i) & ((ridx[i] == 8'h65) ? 8'h77 : 8'hFF)});
      chk("readback err", err, 1'b0);
    end
    repeat (300) @(posedge clock);
    chk("gate first", gate0, wv(0));
    chk("gate second", gate1, wv(1));
    chk("gate third", gate2, wv(2) & 8'h77);
    w = wv(13);
    chk("lowpower div", lpr, w[7:4]);
    // second reset in mid-run
    @(posedge clock);
    nrst <= 1'b0;
    @(posedge clock);
    #1;
    chk("gate first rst", gate0, 8'h8C);
    chk("lowpower div rst", lpr, 4'h1);
    @(posedge clock);
    nrst <= 1'b1;
    apb(1'b0, 8'h66, 8'h00);
    chk("system select rst", rd, 32'hFF);
    end_of_test();
  end
endmodule

//--- src/clock_select_divide.sv
// clock source selection, division and module gating with APB registers
//
// The APB interface to the registers was decided locally.
module clock_select_divide (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // register bus
  input wire clk_ctrl_pkg::apb_req_t apb_in,
  output clk_ctrl_pkg::apb_rsp_t apb_out,
  // source clock ticks
  input wire logic src_pll192,
  input wire logic src_pll48,
  input wire logic src_rc32m,
  input wire logic src_pad16m,
  input wire logic src_rc32k,
  input wire logic src_pad32k,
  // derived clock ticks
  output logic fhs_tick_q,
  output logic sys_tick_q,
  output logic adc_tick_q,
  output logic mic_tick_q,
  output logic usb_phy_tick_q,
  output logic slow_tick_q,
  // module clock enables
  output logic [7:0] module_gate_first_q,
  output logic [7:0] module_gate_second_q,
  output logic [7:0] module_gate_third_q,
  // low-power speed setting
  output logic [3:0] lowpower_div_q
);
  import clk_ctrl_pkg::*;

  // ---------------- register bus ----------------
  logic [7:0] reg_q [NREG];
  logic [NREG-1:0] hit;
  logic [7:0] rd_terms [NREG];
  logic [7:0] rd_byte;
  wire access = apb_in.psel && apb_in.penable;
  wire first_access = access && !apb_out.pready;
  wire wr_take = access && apb_out.pready && apb_in.pwrite;
  wire any_hit = |hit;

  genvar i;
  for (i = 0; i < NREG; i++) begin : g_reg
    assign hit[i] = apb_in.paddr == {2'h0, REG_IDX[i], 2'h0};
    assign rd_terms[i] = hit[i] ? reg_q[i] : 8'h00;
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        reg_q[i] <= REG_RST[i]; // RULE4 RULE19
      end else if (wr_take && hit[i]) begin
        reg_q[i] <= apb_in.pwdata[7:0] & REG_MASK[i]; // RULE6
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    for (int k = 0; k < NREG; k++) begin
      rd_byte = rd_byte | rd_terms[k];
    end
  end

  // one wait state, then ready; unmapped addresses answer with an error
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      apb_out <= '0;
    end else begin
      apb_out.pready <= first_access;
      if (first_access) begin
        apb_out.prdata <= {24'h000000, rd_byte};
        apb_out.pslverr <= !any_hit;
      end
    end
  end

  // ---------------- decoded fields ----------------
  wire [1:0] sys_src_reg = reg_q[S_SYSSEL][SYS_SRC_LSB +: 2]; // RULE7
  wire [SYS_DIV_W-1:0] sys_div_reg = reg_q[S_SYSSEL][SYS_DIV_LSB +: SYS_DIV_W]; // RULE8
  wire [1:0] fhs_sel_reg = {reg_q[S_FHSSEL][FHS_HI_BIT], reg_q[S_SYSSEL][FHS_LO_BIT]}; // RULE10
  wire adc_en = reg_q[S_ADCHI][ADC_EN_BIT]; // RULE11
  wire mic_en = reg_q[S_MICSTEP][MIC_EN_BIT]; // RULE15
  wire [STEP_W-1:0] adc_step = {reg_q[S_ADCHI][ADC_STEPH_LSB +: 3], reg_q[S_ADCSTEP]}; // RULE12
  wire [MOD_W-1:0] adc_mod = {reg_q[S_ADCHI][ADC_MODH_LSB +: 4], reg_q[S_ADCMOD]}; // RULE12
  wire [STEP_W-1:0] mic_step = {4'h0, reg_q[S_MICSTEP][6:0]}; // RULE15
  wire [MOD_W-1:0] mic_mod = {4'h0, reg_q[S_MICMOD]}; // RULE15

  localparam logic [7:0] SYS_RST = REG_RST[S_SYSSEL];
  localparam logic [7:0] FHS_RST = REG_RST[S_FHSSEL];
  localparam logic [7:0] MUX_RST = REG_RST[S_MUX];

  // ---------------- active selections ----------------
  // each selection is taken over only at the end of an output period,
  // so the period in progress completes on the old source, except a high-speed period when the system clock is not the divider
  logic [1:0] sys_src_q;
  logic [SYS_DIV_W-1:0] sys_div_q;
  logic [1:0] fhs_sel_q;
  logic sel32k_q;
  logic mic_sel_q;
  logic usb_sel_q;
  logic [SYS_DIV_W-1:0] div_cnt_q;
  logic [1:0] usb_cnt_q;
  logic fhs_tick;
  logic sys_tick_d;
  logic slow_tick_d;
  logic mic_tick_d;
  logic usb_tick_d;
  logic [1:0] frac_tick;

  assign fhs_tick = (fhs_sel_q == FHS_PLL) ? src_pll192 : // RULE2
                    (fhs_sel_q == FHS_RC) ? src_rc32m : src_pad16m; // RULE1 RULE3 RULE10

  wire div_end = fhs_tick && (div_cnt_q == sys_div_q - 5'h01); // RULE8 RULE9

  assign sys_tick_d = (sys_src_q == SYS_RC32M) ? src_rc32m : // RULE1 RULE7
                      (sys_src_q == SYS_HSDIV) ? div_end : // RULE8
                      (sys_src_q == SYS_PAD16) ? src_pad16m : src_pad32k; // RULE3

  assign slow_tick_d = sel32k_q ? src_pad32k : src_rc32k; // RULE1 RULE17
  assign mic_tick_d = mic_en && (mic_sel_q ? slow_tick_d : frac_tick[1]); // RULE16
  assign usb_tick_d = usb_sel_q ? (src_pll192 && usb_cnt_q == 2'(USB_DIV - 1)) // RULE18
                                : src_pll48;

  wire usb_step = usb_sel_q && src_pll192;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sys_src_q <= SYS_RST[SYS_SRC_LSB +: 2];
      sys_div_q <= SYS_RST[SYS_DIV_LSB +: SYS_DIV_W];
      fhs_sel_q <= {FHS_RST[FHS_HI_BIT], SYS_RST[FHS_LO_BIT]};
    end else if (sys_tick_d) begin
      sys_src_q <= sys_src_reg; // RULE20
      sys_div_q <= sys_div_reg;
      fhs_sel_q <= fhs_sel_reg;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sel32k_q <= MUX_RST[MUX_32K_BIT];
      mic_sel_q <= MUX_RST[MUX_MIC_BIT];
      usb_sel_q <= MUX_RST[MUX_USB_BIT];
    end else begin
      if (slow_tick_d) begin
        sel32k_q <= reg_q[S_MUX][MUX_32K_BIT]; // RULE20
      end
      if (mic_tick_d || !mic_en) begin
        mic_sel_q <= reg_q[S_MUX][MUX_MIC_BIT]; // RULE20
      end
      if (usb_tick_d) begin
        usb_sel_q <= reg_q[S_MUX][MUX_USB_BIT]; // RULE20
      end
    end
  end

  // ---------------- counters ----------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_cnt_q <= '0;
      usb_cnt_q <= '0;
    end else begin
      if (sys_src_q != SYS_HSDIV) begin
        div_cnt_q <= '0;
      end else if (fhs_tick) begin
        div_cnt_q <= div_end ? '0 : div_cnt_q + 5'h01; // RULE8
      end
      if (!usb_sel_q) begin
        usb_cnt_q <= '0;
      end else if (usb_step) begin
        usb_cnt_q <= usb_tick_d ? 2'h0 : usb_cnt_q + 2'h1; // RULE18
      end
    end
  end

  // ---------------- fractional dividers: 0 converter, 1 mic ----------------
  logic [1:0] frac_en;
  logic [STEP_W-1:0] frac_step [2];
  logic [MOD_W-1:0] frac_mod [2];
  assign frac_en = {mic_en, adc_en}; // RULE11 RULE15
  assign frac_step[0] = adc_step;
  assign frac_step[1] = mic_step;
  assign frac_mod[0] = adc_mod;
  assign frac_mod[1] = mic_mod;

  genvar f;
  for (f = 0; f < 2; f++) begin : g_frac
    // output stays below half the source rate only if mod >= 2*step
    frac_div #(
      .SW(STEP_W),
      .MW(MOD_W)
    ) u_div (
      .clock(clock),
      .nrst(nrst),
      .enable(frac_en[f]),
      .tick_in(fhs_tick),
      .step(frac_step[f]),
      .mod(frac_mod[f]),
      .tick_q(frac_tick[f]) // RULE13 RULE14
    );
  end
  assign adc_tick_q = frac_tick[0]; // RULE11 RULE13

  // ---------------- outputs ----------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fhs_tick_q <= 1'b0;
      sys_tick_q <= 1'b0;
      mic_tick_q <= 1'b0;
      usb_phy_tick_q <= 1'b0;
      slow_tick_q <= 1'b0;
      lowpower_div_q <= MUX_RST[MUX_LPR_LSB +: 4];
    end else begin
      fhs_tick_q <= fhs_tick;
      sys_tick_q <= sys_tick_d;
      mic_tick_q <= mic_tick_d; // RULE16
      usb_phy_tick_q <= usb_tick_d; // RULE18
      slow_tick_q <= slow_tick_d; // RULE17
      lowpower_div_q <= reg_q[S_MUX][MUX_LPR_LSB +: 4]; // RULE19
    end
  end

  // gates follow their registers at a system clock period boundary
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      module_gate_first_q <= REG_RST[S_GATE0];
      module_gate_second_q <= REG_RST[S_GATE1];
      module_gate_third_q <= REG_RST[S_GATE2];
    end else if (sys_tick_d) begin
      module_gate_first_q <= reg_q[S_GATE0]; // RULE4 RULE20
      module_gate_second_q <= reg_q[S_GATE1]; // RULE5
      module_gate_third_q <= reg_q[S_GATE2]; // RULE6
    end
  end

  // ---------------- assertions ----------------
  sequence bus_setup_s;
    apb_in.psel && !apb_in.penable;
  endsequence
  sequence bus_wait_s;
    access && !apb_out.pready;
  endsequence
  sequence gate0_write_s;
    wr_take && hit[S_GATE0];
  endsequence

  bus_wait_state_a: assert property (@(posedge clock) disable iff (!nrst)
    bus_setup_s ##1 bus_wait_s |=> apb_out.pready)
    else $error("bus access not answered after one wait state");
  gate_write_apply_a: assert property (@(posedge clock) disable iff (!nrst) // RULE4
    gate0_write_s ##1 (!wr_take [*1] ##0 sys_tick_d) |=> module_gate_first_q == $past(apb_in.pwdata[7:0], 2))
    else $error("first gate register not applied at boundary");
  gate_reserved_zero_a: assert property (@(posedge clock) disable iff (!nrst) // RULE6
    module_gate_third_q[3] == 1'b0 && module_gate_third_q[7] == 1'b0)
    else $error("reserved gate bits set");
  gate_hold_a: assert property (@(posedge clock) disable iff (!nrst) // RULE20
    !sys_tick_d |=> $stable(module_gate_second_q))
    else $error("gate changed inside a system period");
  sys_pad32k_a: assert property (@(posedge clock) disable iff (!nrst) // RULE7
    nrst && sys_src_q == SYS_PAD32K && src_pad32k |=> sys_tick_q)
    else $error("32k pad source not passed to system clock");
  sys_div_end_a: assert property (@(posedge clock) disable iff (!nrst) // RULE8
    sys_src_q == SYS_HSDIV && fhs_tick && div_cnt_q != sys_div_q - 5'h01 |=> !sys_tick_q)
    else $error("system tick before divider count ended");
  fhs_pll_a: assert property (@(posedge clock) disable iff (!nrst) // RULE10
    fhs_sel_q == FHS_PLL |=> fhs_tick_q == $past(src_pll192))
    else $error("high-speed tick does not follow PLL");
  adc_off_a: assert property (@(posedge clock) disable iff (!nrst) // RULE11
    !adc_en ##1 !adc_en |-> !adc_tick_q)
    else $error("converter clock ran while disabled");
  mic_slow_a: assert property (@(posedge clock) disable iff (!nrst) // RULE16
    mic_en && mic_sel_q && slow_tick_d |=> mic_tick_q)
    else $error("mic pin missed a 32k tick");
  slow_rc_a: assert property (@(posedge clock) disable iff (!nrst) // RULE17
    nrst && !sel32k_q && src_rc32k |=> slow_tick_q)
    else $error("internal 32k tick lost");
  usb_div_a: assert property (@(posedge clock) disable iff (!nrst) // RULE18
    usb_sel_q && src_pll192 && usb_cnt_q == 2'(USB_DIV - 1) |=> usb_phy_tick_q)
    else $error("USB PHY divider tick lost");
  lowpower_follow_a: assert property (@(posedge clock) disable iff (!nrst) // RULE19
    ##1 lowpower_div_q == $past(reg_q[S_MUX][7:4]))
    else $error("low-power divider does not follow register");
  sys_switch_edge_a: assert property (@(posedge clock) disable iff (!nrst) // RULE20
    !$stable(sys_src_q) |-> $past(sys_tick_d))
    else $error("system source switched mid-period");

  // register bus answers
  bus_ready_pulse_a: assert property (@(posedge clock) disable iff (!nrst)
    apb_out.pready |=> !apb_out.pready)
    else $error("ready stood longer than one cycle");
  bus_unmapped_err_a: assert property (@(posedge clock) disable iff (!nrst)
    first_access && !any_hit |=> apb_out.pslverr && apb_out.prdata == 32'h00000000)
    else $error("unmapped access not refused");
  bus_mapped_ok_a: assert property (@(posedge clock) disable iff (!nrst)
    first_access && any_hit |=> !apb_out.pslverr)
    else $error("mapped access answered with an error");
  mux_write_land_a: assert property (@(posedge clock) disable iff (!nrst) // RULE19
    wr_take && hit[S_MUX] |=> reg_q[S_MUX] == $past(apb_in.pwdata[7:0]))
    else $error("mux register write lost");

  // gates move only at a system tick, and then to the register value
  gate_first_follow_a: assert property (@(posedge clock) disable iff (!nrst) // RULE4
    sys_tick_d |=> module_gate_first_q == $past(reg_q[S_GATE0]))
    else $error("first gate did not take its register");
  gate_second_follow_a: assert property (@(posedge clock) disable iff (!nrst) // RULE5
    sys_tick_d |=> module_gate_second_q == $past(reg_q[S_GATE1]))
    else $error("second gate did not take its register");
  gate_third_follow_a: assert property (@(posedge clock) disable iff (!nrst) // RULE6
    sys_tick_d |=> module_gate_third_q == $past(reg_q[S_GATE2]))
    else $error("third gate did not take its register");
  gate_first_hold_a: assert property (@(posedge clock) disable iff (!nrst) // RULE20
    !sys_tick_d |=> $stable(module_gate_first_q))
    else $error("first gate changed inside a system period");
  gate_third_hold_a: assert property (@(posedge clock) disable iff (!nrst) // RULE20
    !sys_tick_d |=> $stable(module_gate_third_q))
    else $error("third gate changed inside a system period");

  // selected sources reach their outputs one cycle later
  sys_rc_pass_a: assert property (@(posedge clock) disable iff (!nrst) // RULE7
    nrst && sys_src_q == SYS_RC32M && src_rc32m |=> sys_tick_q)
    else $error("RC source not passed to system clock");
  sys_pad16_pass_a: assert property (@(posedge clock) disable iff (!nrst) // RULE3
    nrst && sys_src_q == SYS_PAD16 && src_pad16m |=> sys_tick_q)
    else $error("16M pad source not passed to system clock");
  sys_div_tick_a: assert property (@(posedge clock) disable iff (!nrst) // RULE8
    nrst && sys_src_q == SYS_HSDIV && div_end |=> sys_tick_q)
    else $error("system tick missing at divider end");
  fhs_rc_a: assert property (@(posedge clock) disable iff (!nrst) // RULE1
    nrst && fhs_sel_q == FHS_RC |=> fhs_tick_q == $past(src_rc32m))
    else $error("high-speed tick does not follow RC");
  fhs_pad_a: assert property (@(posedge clock) disable iff (!nrst) // RULE3
    nrst && fhs_sel_q[1] |=> fhs_tick_q == $past(src_pad16m))
    else $error("high-speed tick does not follow pad");
  mic_off_a: assert property (@(posedge clock) disable iff (!nrst) // RULE15
    !mic_en |=> !mic_tick_q)
    else $error("mic pin ticked while disabled");
  mic_div_pass_a: assert property (@(posedge clock) disable iff (!nrst) // RULE16
    nrst && mic_en && !mic_sel_q && frac_tick[1] |=> mic_tick_q)
    else $error("mic pin missed a divider tick");
  slow_pad_a: assert property (@(posedge clock) disable iff (!nrst) // RULE17
    nrst && sel32k_q && src_pad32k |=> slow_tick_q)
    else $error("pad 32k tick lost");
  usb_pll48_a: assert property (@(posedge clock) disable iff (!nrst) // RULE18
    nrst && !usb_sel_q && src_pll48 |=> usb_phy_tick_q)
    else $error("48M tick not passed to USB PHY clock");

  // selection switches only at a tick of the output that it feeds, the high-speed one at a system tick
  fhs_switch_edge_a: assert property (@(posedge clock) disable iff (!nrst) // RULE20
    !$stable(fhs_sel_q) |-> $past(sys_tick_d))
    else $error("high-speed source switched mid-period");
  slow_switch_edge_a: assert property (@(posedge clock) disable iff (!nrst) // RULE20
    !$stable(sel32k_q) |-> $past(slow_tick_d))
    else $error("32k source switched mid-period");
  usb_switch_edge_a: assert property (@(posedge clock) disable iff (!nrst) // RULE20
    !$stable(usb_sel_q) |-> $past(usb_tick_d))
    else $error("USB PHY source switched mid-period");
endmodule

//--- src/frac_div.sv
// step/mod fractional divider producing a tick train
module frac_div #(
  parameter int SW = 11,
  parameter int MW = 12
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // control
  input wire logic enable,
  input wire logic tick_in,
  input wire logic [SW-1:0] step,
  input wire logic [MW-1:0] mod,
  // output
  output logic tick_q
);
  logic [MW:0] acc_q;
  logic [MW:0] acc_d;
  logic [MW:0] sum;
  logic wrap;

  assign sum = acc_q + (MW+1)'(step);
  assign wrap = enable && tick_in && (sum >= (MW+1)'(mod));
  assign acc_d = !enable ? '0 : !tick_in ? acc_q : wrap ? sum - (MW+1)'(mod) : sum;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      acc_q <= '0;
      tick_q <= 1'b0;
    end else begin
      acc_q <= acc_d; // RULE13
      tick_q <= wrap;
    end
  end

  frac_wrap_a: assert property (@(posedge clock) disable iff (!nrst) // RULE13
    enable && tick_in && (sum >= (MW+1)'(mod)) |=> tick_q)
    else $error("fractional divider missed a wrap");
  frac_quiet_a: assert property (@(posedge clock) disable iff (!nrst) // RULE13
    !tick_in |=> !tick_q)
    else $error("fractional divider ticked without a source tick");
endmodule
